// [shared/sgc_pkg.sv]
// Package for the system address decoder and global control bank.
// Assumes one system clock and a simple single-cycle bus master request port.
package sgc_pkg;

   // Decoded regions, one-hot
   typedef enum logic [23:0] {
      SEL_NONE  = 24'h000000,
      SEL_FLASH = 24'h000001,
      SEL_SRAM  = 24'h000002,
      SEL_GCR   = 24'h000004,
      SEL_CLK   = 24'h000008,
      SEL_INTM  = 24'h000010,
      SEL_GPIO  = 24'h000020,
      SEL_FMC   = 24'h000040,
      SEL_EBIC  = 24'h000080,
      SEL_EBI   = 24'h000100,
      SEL_WDOG  = 24'h000200,
      SEL_TMR01 = 24'h000400,
      SEL_TWI   = 24'h000800,
      SEL_SPI0  = 24'h001000,
      SEL_SPI1  = 24'h002000,
      SEL_PWMA  = 24'h004000,
      SEL_UART0 = 24'h008000,
      SEL_ADC   = 24'h010000,
      SEL_TMR23 = 24'h020000,
      SEL_PWMB  = 24'h040000,
      SEL_UART1 = 24'h080000,
      SEL_TICK  = 24'h100000,
      SEL_EIC   = 24'h200000,
      SEL_SCB   = 24'h400000
   } sgc_sel_e;

   typedef struct packed {
      logic [31:0] lo;
      logic [31:0] hi;
      sgc_sel_e    sel;
   } sgc_region_s;

   localparam int NUM_REGIONS = 23;
   localparam sgc_region_s REGION_MAP [NUM_REGIONS] = '{
      '{32'h0000_0000, 32'h0000_FFFF, SEL_FLASH},
      '{32'h2000_0000, 32'h2000_0FFF, SEL_SRAM},
      '{32'h5000_0000, 32'h5000_01FF, SEL_GCR},
      '{32'h5000_0200, 32'h5000_02FF, SEL_CLK},
      '{32'h5000_0300, 32'h5000_03FF, SEL_INTM},
      '{32'h5000_4000, 32'h5000_7FFF, SEL_GPIO},
      '{32'h5000_C000, 32'h5000_FFFF, SEL_FMC},
      '{32'h5001_0000, 32'h5001_3FFF, SEL_EBIC},
      '{32'h6000_0000, 32'h6001_FFFF, SEL_EBI},
      '{32'h4000_4000, 32'h4000_7FFF, SEL_WDOG},
      '{32'h4001_0000, 32'h4001_3FFF, SEL_TMR01},
      '{32'h4002_0000, 32'h4002_3FFF, SEL_TWI},
      '{32'h4003_0000, 32'h4003_3FFF, SEL_SPI0},
      '{32'h4003_4000, 32'h4003_7FFF, SEL_SPI1},
      '{32'h4004_0000, 32'h4004_3FFF, SEL_PWMA},
      '{32'h4005_0000, 32'h4005_3FFF, SEL_UART0},
      '{32'h400E_0000, 32'h400E_FFFF, SEL_ADC},
      '{32'h4011_0000, 32'h4011_3FFF, SEL_TMR23},
      '{32'h4014_0000, 32'h4014_3FFF, SEL_PWMB},
      '{32'h4015_0000, 32'h4015_3FFF, SEL_UART1},
      '{32'hE000_E010, 32'hE000_E0FF, SEL_TICK},
      '{32'hE000_E100, 32'hE000_ECFF, SEL_EIC},
      '{32'hE000_ED00, 32'hE000_ED8F, SEL_SCB}
   };

   // Global control register offsets within its window
   localparam logic [8:0] OFS_PART_IDENTITY   = 9'h000;
   localparam logic [8:0] OFS_RESET_ORIGIN    = 9'h004;
   localparam logic [8:0] OFS_CORE_RESET      = 9'h008;
   localparam logic [8:0] OFS_MODULE_RESET    = 9'h00C;
   localparam logic [8:0] OFS_SUPPLY_DROOP    = 9'h018;
   localparam logic [8:0] OFS_POWERUP_RESET   = 9'h024;
   localparam logic [8:0] OFS_PORT0_FUNC      = 9'h030;
   localparam logic [8:0] OFS_PORT1_FUNC      = 9'h034;
   localparam logic [8:0] OFS_PORT2_FUNC      = 9'h038;
   localparam logic [8:0] OFS_PORT3_FUNC      = 9'h03C;
   localparam logic [8:0] OFS_PORT4_INPUT     = 9'h040;
   localparam logic [8:0] OFS_WRITE_LOCK      = 9'h100;

   // Reset values and writable masks
   localparam logic [31:0] RST_PORT4_INPUT    = 32'h0000_00C0;
   localparam logic [31:0] MASK_RESET_ORIGIN  = 32'h0000_00BF;
   localparam logic [31:0] MASK_CORE_RESET    = 32'h0000_000B;
   localparam logic [31:0] MASK_MODULE_RESET  = 32'h1033_313E;
   localparam logic [31:0] MASK_BYTE          = 32'h0000_00FF;

   // Core reset control bit positions
   localparam int BIT_CHIP_RESET = 0;
   localparam int BIT_CPU_RESET  = 1;

   // Reset-origin flag bit positions
   localparam int FLAG_POWERUP  = 0;
   localparam int FLAG_PIN      = 1;
   localparam int FLAG_WATCHDOG = 2;
   localparam int FLAG_LOWVOLT  = 3;
   localparam int FLAG_DROOP    = 4;
   localparam int FLAG_SYSREQ   = 5;
   localparam int FLAG_CPU      = 7;

   // Unlock sequence bytes
   localparam logic [7:0] UNLOCK_KEY0 = 8'h59;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h16;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h88;

   // One-shot reset pulse length in cycles
   localparam logic [1:0] ONESHOT_CYCLES = 2'h2;

   // Request carried from the bus master
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sgc_req_s;

   // Answer back to the bus master
   typedef struct packed {
      logic        ready;
      logic        error;
      logic [31:0] rdata;
   } sgc_rsp_s;

endpackage : sgc_pkg

// [hdl/sgc_top.sv]
// System address decoder and global control register bank.
// Assumes a master that holds one request for one cycle and takes the answer on the next.
// Contract
// RL1: Flash window 0x0000_0000 to 0x0000_FFFF decoded
// RL2: SRAM 4 KB window decoded
// RL3: Global, clock, interrupt-mux windows on high-speed bus
// RL4: Port controller and flash controller windows decoded
// RL5: External bus control and device space decoded
// RL6: Watchdog, timer 0/1, two-wire windows decoded
// RL7: Serial interface 0 and 1 decoded
// RL8: Modulator group A and serial port 0
// RL9: Converter 64 KB and timer 2/3 windows
// RL10: Modulator group B and serial port 1
// RL11: Tick timer, interrupt controller, control block
// RL12: Little-endian byte order only
// RL13: Identity register returns fixed part code
// RL14: Every reset cause latched as readable flag
// RL15: Protected bits writable only after unlock sequence
// RL16: Flags clear only by writing one
// RL17: One-shot reset bits self-clear after two cycles
// RL18: Module reset held until software clears
// RL19: Unmapped accesses error and change nothing
// RL20: Reserved bits read zero, ignore writes
module sgc_top #(
   parameter logic [31:0] PART_CODE = 32'h0000_A5A5 // Arbitrary value
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // Bus master request and answer
   input  wire sgc_pkg::sgc_req_s busReq,
   output sgc_pkg::sgc_rsp_s      busRsp,
   output sgc_pkg::sgc_sel_e      regionSel,
   // Reset cause events, one-cycle pulses
   input  wire logic             evPowerup,
   input  wire logic             evPin,
   input  wire logic             evWatchdog,
   input  wire logic             evLowVolt,
   input  wire logic             evDroop,
   input  wire logic             evSysReq,
   // Reset controls out
   output logic                  chipReset,
   output logic                  cpuReset,
   output logic [31:0]           moduleReset,
   // Configuration outputs
   output logic [31:0]           supplyDroopCfg,
   output logic [31:0]           powerupResetCfg,
   output logic [31:0]           portFuncSel [5],
   output logic                  unlocked
);
   import sgc_pkg::*;

   sgc_sel_e    decSel;
   logic [8:0]  gcrOfs;
   logic        gcrHit;
   logic        regKnown;
   logic        wrEn;
   logic [31:0] rdVal;
   logic [31:0] coreReset_r;
   logic [31:0] resetOrigin_r;
   logic [1:0]  unlockStep_r;
   logic [1:0]  oneshotCnt_r;
   logic        unlocked_r;
   logic [31:0] portFunc_r [5];

   // Linear search; windows never overlap, so order does not matter [RL1] [RL2] [RL3] [RL4] [RL5]
   always_comb begin // [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
      decSel = SEL_NONE;
      for (int i = 0; i < NUM_REGIONS; i++) begin
         if (busReq.addr >= REGION_MAP[i].lo && busReq.addr <= REGION_MAP[i].hi) begin
            decSel = REGION_MAP[i].sel;
         end
      end
   end

   assign gcrOfs = busReq.addr[8:0];
   assign gcrHit = busReq.valid && (decSel == SEL_GCR);

   always_comb begin
      regKnown = 1'b1;
      rdVal    = 32'h0000_0000;
      unique case (gcrOfs)
         OFS_PART_IDENTITY: rdVal = PART_CODE; // [RL13]
         OFS_RESET_ORIGIN:  rdVal = resetOrigin_r & MASK_RESET_ORIGIN; // [RL20]
         OFS_CORE_RESET:    rdVal = coreReset_r & MASK_CORE_RESET;
         OFS_MODULE_RESET:  rdVal = moduleReset & MASK_MODULE_RESET;
         OFS_SUPPLY_DROOP:  rdVal = supplyDroopCfg & MASK_BYTE;
         OFS_POWERUP_RESET: rdVal = powerupResetCfg;
         OFS_PORT0_FUNC:    rdVal = portFunc_r[0];
         OFS_PORT1_FUNC:    rdVal = portFunc_r[1];
         OFS_PORT2_FUNC:    rdVal = portFunc_r[2];
         OFS_PORT3_FUNC:    rdVal = portFunc_r[3];
         OFS_PORT4_INPUT:   rdVal = portFunc_r[4];
         OFS_WRITE_LOCK:    rdVal = {31'h0000_0000, unlocked_r};
         default:           regKnown = 1'b0;
      endcase
   end

   // Unknown offsets inside the global window also error, writes dropped [RL19]
   assign wrEn = gcrHit && busReq.write && regKnown;

   // Answer registered one cycle after request; data is little-endian word [RL12]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busRsp    <= '0;
         regionSel <= SEL_NONE;
      end else begin
         busRsp.ready <= busReq.valid;
         busRsp.error <= busReq.valid && ((decSel == SEL_NONE) || (gcrHit && !regKnown)); // [RL19]
         busRsp.rdata <= (gcrHit && !busReq.write) ? rdVal : 32'h0000_0000;
         regionSel    <= busReq.valid ? decSel : SEL_NONE;
      end
   end

   // Unlock walks 59h,16h,88h; any other write restarts, any write when open relocks [RL15]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         unlockStep_r <= 2'h0;
         unlocked_r   <= 1'b0;
      end else if (wrEn && gcrOfs == OFS_WRITE_LOCK) begin
         if (unlocked_r) begin
            unlocked_r   <= 1'b0;
            unlockStep_r <= 2'h0;
         end else if (unlockStep_r == 2'h0 && busReq.wdata[7:0] == UNLOCK_KEY0) begin
            unlockStep_r <= 2'h1;
         end else if (unlockStep_r == 2'h1 && busReq.wdata[7:0] == UNLOCK_KEY1) begin
            unlockStep_r <= 2'h2;
         end else if (unlockStep_r == 2'h2 && busReq.wdata[7:0] == UNLOCK_KEY2) begin
            unlockStep_r <= 2'h0;
            unlocked_r   <= 1'b1;
         end else begin
            unlockStep_r <= 2'h0;
         end
      end
   end

   // Core reset: protected, one-shot bits drop after two cycles [RL15] [RL17]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         coreReset_r  <= 32'h0000_0000;
         oneshotCnt_r <= 2'h0;
      end else if (wrEn && gcrOfs == OFS_CORE_RESET && unlocked_r) begin
         coreReset_r  <= busReq.wdata & MASK_CORE_RESET; // [RL20]
         oneshotCnt_r <= 2'h0;
      end else if (coreReset_r[BIT_CHIP_RESET] || coreReset_r[BIT_CPU_RESET]) begin
         if (oneshotCnt_r == ONESHOT_CYCLES - 2'h1) begin
            coreReset_r[BIT_CHIP_RESET] <= 1'b0; // [RL17]
            coreReset_r[BIT_CPU_RESET]  <= 1'b0;
            oneshotCnt_r                <= 2'h0;
         end else begin
            oneshotCnt_r <= oneshotCnt_r + 2'h1;
         end
      end
   end

   // Module resets hold until software writes zero [RL18]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         moduleReset <= 32'h0000_0000;
      end else if (wrEn && gcrOfs == OFS_MODULE_RESET) begin
         moduleReset <= busReq.wdata & MASK_MODULE_RESET; // [RL20]
      end
   end

   // Sticky flags: event set beats a same-cycle write-one clear [RL14] [RL16]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         resetOrigin_r <= 32'h0000_0000;
      end else begin
         resetOrigin_r <= ((wrEn && gcrOfs == OFS_RESET_ORIGIN)
                           ? (resetOrigin_r & ~busReq.wdata) : resetOrigin_r)
                          & MASK_RESET_ORIGIN;
         if (evPowerup || coreReset_r[BIT_CHIP_RESET]) resetOrigin_r[FLAG_POWERUP] <= 1'b1; // [RL14]
         if (evPin)      resetOrigin_r[FLAG_PIN]      <= 1'b1;
         if (evWatchdog) resetOrigin_r[FLAG_WATCHDOG] <= 1'b1;
         if (evLowVolt)  resetOrigin_r[FLAG_LOWVOLT]  <= 1'b1;
         if (evDroop)    resetOrigin_r[FLAG_DROOP]    <= 1'b1;
         if (evSysReq)   resetOrigin_r[FLAG_SYSREQ]   <= 1'b1;
         if (coreReset_r[BIT_CPU_RESET]) resetOrigin_r[FLAG_CPU] <= 1'b1;
      end
   end

   // Droop and power-up controls are protected; field layout left open [RL15]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         supplyDroopCfg  <= 32'h0000_0000;
         powerupResetCfg <= 32'h0000_0000;
      end else if (wrEn && unlocked_r) begin
         if (gcrOfs == OFS_SUPPLY_DROOP)  supplyDroopCfg  <= busReq.wdata & MASK_BYTE;
         if (gcrOfs == OFS_POWERUP_RESET) powerupResetCfg <= busReq.wdata;
      end
   end

   // Pin function selects, unprotected
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int p = 0; p < 4; p++) portFunc_r[p] <= 32'h0000_0000;
         portFunc_r[4] <= RST_PORT4_INPUT;
      end else if (wrEn) begin
         for (int p = 0; p < 5; p++) begin
            if (gcrOfs == OFS_PORT0_FUNC + 9'(4 * p)) portFunc_r[p] <= busReq.wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         chipReset <= 1'b0;
         cpuReset  <= 1'b0;
         unlocked  <= 1'b0;
         for (int p = 0; p < 5; p++) portFuncSel[p] <= 32'h0000_0000;
      end else begin
         chipReset <= coreReset_r[BIT_CHIP_RESET];
         cpuReset  <= coreReset_r[BIT_CPU_RESET];
         unlocked  <= unlocked_r;
         for (int p = 0; p < 5; p++) portFuncSel[p] <= portFunc_r[p];
      end
   end

   // Assertions
   unmapped_error_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL19]
      (busReq.valid && decSel == SEL_NONE) |=> (busRsp.ready && busRsp.error))
      else $error("unmapped access not errored");
   identity_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL13]
      (gcrHit && !busReq.write && gcrOfs == OFS_PART_IDENTITY) |=> (busRsp.rdata == PART_CODE))
      else $error("identity read wrong");
   oneshot_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL17]
      ($rose(coreReset_r[BIT_CPU_RESET]) && !wrEn) |=> coreReset_r[BIT_CPU_RESET] ##1 !coreReset_r[BIT_CPU_RESET])
      else $error("one-shot did not clear in two cycles");
   // Only checked with the one-shots idle, so their self-clear cannot look like a write
   locked_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL15]
      (wrEn && !unlocked_r && gcrOfs == OFS_CORE_RESET && !coreReset_r[BIT_CHIP_RESET]
         && !coreReset_r[BIT_CPU_RESET]) |=> $stable(coreReset_r))
      else $error("locked write took effect");
   droop_locked_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL15]
      (wrEn && !unlocked_r && gcrOfs == OFS_SUPPLY_DROOP) |=> $stable(supplyDroopCfg))
      else $error("locked droop write took effect");
   chip_oneshot_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL17]
      ($rose(coreReset_r[BIT_CHIP_RESET]) && !wrEn) |=> coreReset_r[BIT_CHIP_RESET] ##1 !coreReset_r[BIT_CHIP_RESET])
      else $error("chip one-shot did not clear in two cycles");
   unmapped_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL19]
      (busReq.valid && busReq.write && decSel == SEL_NONE) |=> ($stable(moduleReset) && $stable(portFunc_r[0])))
      else $error("unmapped write changed a register");
   flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL16]
      (resetOrigin_r[FLAG_WATCHDOG] && !(wrEn && gcrOfs == OFS_RESET_ORIGIN && busReq.wdata[FLAG_WATCHDOG]))
         |=> resetOrigin_r[FLAG_WATCHDOG])
      else $error("flag lost without write-one");
   flag_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL14]
      evDroop |=> resetOrigin_r[FLAG_DROOP])
      else $error("droop cause not recorded");
   module_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL18]
      (moduleReset[BIT_CPU_RESET] && !(wrEn && gcrOfs == OFS_MODULE_RESET)) |=> moduleReset[BIT_CPU_RESET])
      else $error("module reset released on its own");
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL20]
      (moduleReset & ~MASK_MODULE_RESET) == 32'h0000_0000)
      else $error("reserved bit set");
   flash_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL1]
      (busReq.valid && busReq.addr <= 32'h0000_FFFF) |=> (regionSel == SEL_FLASH))
      else $error("flash not selected");
   // Window checks written from the address map itself, not from the decode table
   sram_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL2]
      (busReq.valid && busReq.addr >= 32'h2000_0000 && busReq.addr <= 32'h2000_0FFF) |=> (regionSel == SEL_SRAM))
      else $error("sram not selected");
   global_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL3]
      (busReq.valid && busReq.addr >= 32'h5000_0000 && busReq.addr <= 32'h5000_01FF) |=> (regionSel == SEL_GCR))
      else $error("global control not selected");
   flashctl_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL4]
      (busReq.valid && busReq.addr >= 32'h5000_C000 && busReq.addr <= 32'h5000_FFFF) |=> (regionSel == SEL_FMC))
      else $error("flash controller not selected");
   extspace_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL5]
      (busReq.valid && busReq.addr >= 32'h6000_0000 && busReq.addr <= 32'h6001_FFFF) |=> (regionSel == SEL_EBI))
      else $error("external space not selected");
   watchdog_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL6]
      (busReq.valid && busReq.addr >= 32'h4000_4000 && busReq.addr <= 32'h4000_7FFF) |=> (regionSel == SEL_WDOG))
      else $error("watchdog not selected");
   serial1_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL7]
      (busReq.valid && busReq.addr >= 32'h4003_4000 && busReq.addr <= 32'h4003_7FFF) |=> (regionSel == SEL_SPI1))
      else $error("serial interface 1 not selected");
   port0_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL8]
      (busReq.valid && busReq.addr >= 32'h4005_0000 && busReq.addr <= 32'h4005_3FFF) |=> (regionSel == SEL_UART0))
      else $error("serial port 0 not selected");
   converter_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL9]
      (busReq.valid && busReq.addr >= 32'h400E_0000 && busReq.addr <= 32'h400E_FFFF) |=> (regionSel == SEL_ADC))
      else $error("converter not selected");
   port1_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL10]
      (busReq.valid && busReq.addr >= 32'h4015_0000 && busReq.addr <= 32'h4015_3FFF) |=> (regionSel == SEL_UART1))
      else $error("serial port 1 not selected");
   ctlblock_decode_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RL11]
      (busReq.valid && busReq.addr >= 32'hE000_ED00 && busReq.addr <= 32'hE000_ED8F) |=> (regionSel == SEL_SCB))
      else $error("control block not selected");

endmodule : sgc_top

// [tb/sgc_master_model.sv]
// Bus master model standing in for the processor core on the request port.
// Assumes the decoder answers each single-cycle request one cycle after it is taken.
module sgc_master_model (
   // Clock
   input  wire logic              clk_sys,
   // Request and answer
   output sgc_pkg::sgc_req_s      busReq,
   input  wire sgc_pkg::sgc_rsp_s busRsp,
   // Status to the bench
   output logic                   timedOut
);
   timeunit 1ns;
   timeprecision 100ps;
   import sgc_pkg::*;

   initial begin
      busReq   = '0;
      timedOut = 1'b0;
   end

   // Whole 32-bit words only, so there is no byte lane to get wrong
   task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                         output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk_sys);
      #1;
      busReq = '{1'b1, wr, a, wd};
      @(posedge clk_sys);
      #1;
      // Released lines show the inverse so a stale value cannot pass
      busReq = '{1'b0, ~wr, ~a, ~wd};
      n = 0;
      while (busRsp.ready !== 1'b1 && n < 8) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (busRsp.ready !== 1'b1) timedOut = 1'b1;
      rd = busRsp.rdata;
      er = busRsp.error;
   endtask : access

   // Unlock bytes in order
   task automatic unlock();
      logic [31:0] r;
      logic        e;
      access(1'b1, 32'h5000_0100, {24'h0, UNLOCK_KEY0}, r, e);
      access(1'b1, 32'h5000_0100, {24'h0, UNLOCK_KEY1}, r, e);
      access(1'b1, 32'h5000_0100, {24'h0, UNLOCK_KEY2}, r, e);
   endtask : unlock
endmodule : sgc_master_model

// [tb/system_address_decode_and_global_control_test.sv]
// Self-checking bench for the address decoder and global control bank.
// Assumes the master model above and a 20 MHz clock.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module system_address_decode_and_global_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import sgc_pkg::*;

   localparam logic [31:0] PART = 32'h0000_3C3C; // Arbitrary value
   localparam logic [31:0] G    = 32'h5000_0000;

   logic        clk_sys = 1'b0;
   logic        arst_n  = 1'b0;
   logic [5:0]  ev      = '0;
   sgc_req_s    busReq;
   sgc_rsp_s    busRsp;
   sgc_sel_e    regionSel;
   logic        chipReset, cpuReset, unlocked, timedOut;
   logic [31:0] moduleReset, supplyDroopCfg, powerupResetCfg;
   logic [31:0] portFuncSel [5];
   int          num_errors = 0;
   int          cmp_count  = 0;
   int          chipHi     = 0;
   int          cpuHi      = 0;

   always #25 clk_sys = ~clk_sys;

   sgc_top #(.PART_CODE(PART)) DUT (
      .clk_sys(clk_sys), .arst_n(arst_n), .busReq(busReq), .busRsp(busRsp), .regionSel(regionSel),
      .evPowerup(ev[0]), .evPin(ev[1]), .evWatchdog(ev[2]), .evLowVolt(ev[3]), .evDroop(ev[4]),
      .evSysReq(ev[5]), .chipReset(chipReset), .cpuReset(cpuReset), .moduleReset(moduleReset),
      .supplyDroopCfg(supplyDroopCfg), .powerupResetCfg(powerupResetCfg),
      .portFuncSel(portFuncSel), .unlocked(unlocked));

   sgc_master_model M (.clk_sys(clk_sys), .busReq(busReq), .busRsp(busRsp), .timedOut(timedOut));

   always @(posedge clk_sys) begin
      if (chipReset === 1'b1) chipHi++;
      if (cpuReset === 1'b1) cpuHi++;
   end

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      M.access(wr, a, d, r, e);
      if (timedOut) begin
         num_errors++;
         close_out();
      end
   endtask : acc

   // Reads compare data; writes only compare the error flag
   task automatic op(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic expErr, input logic [31:0] expRd);
      logic [31:0] r;
      logic        e;
      acc(wr, a, d, r, e);
      `CHK(e, expErr)
      if (!wr) `CHK(r, expRd)
   endtask : op

   initial begin
      static logic [8:0]  ofs [12] = '{9'h000, 9'h004, 9'h008, 9'h00C, 9'h018, 9'h024,
                                9'h030, 9'h034, 9'h038, 9'h03C, 9'h040, 9'h100};
      static logic [31:0] gap [5]  = '{32'h0001_0000, 32'h2000_1000, 32'h5000_0400, 32'h4000_0000, 32'hE000_E000};
      logic [31:0] r;
      logic        e;
      repeat (20) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      for (int i = 0; i < 12; i++) op(1'b0, G + ofs[i], 0, 1'b0, (i == 0) ? PART : (i == 10) ? 32'hC0 : 0);
      `CHK(portFuncSel[4], 32'h0000_00C0)
      $display("test reset_values done");
      for (int i = 0; i < NUM_REGIONS; i++) begin
         acc(1'b0, REGION_MAP[i].lo, 0, r, e);
         `CHK(regionSel, REGION_MAP[i].sel)
         acc(1'b0, REGION_MAP[i].hi, 0, r, e);
         `CHK(regionSel, REGION_MAP[i].sel)
      end
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, gap[i], 0, r, e);
         `CHK(e, 1'b1)
         `CHK(regionSel, SEL_NONE)
      end
      $display("test decode done");
      op(1'b1, G + 32'h8, 32'h1, 1'b0, 0);
      op(1'b0, G + 32'h8, 0, 1'b0, 0);
      op(1'b1, G + 32'h18, 32'hFFFF_FFFF, 1'b0, 0);
      op(1'b0, G + 32'h18, 0, 1'b0, 0);
      op(1'b1, G + 32'h24, 32'h1234_5678, 1'b0, 0);
      op(1'b0, G + 32'h24, 0, 1'b0, 0);
      `CHK(powerupResetCfg, 32'h0)
      op(1'b1, G + 32'h100, 32'h59, 1'b0, 0);
      op(1'b1, G + 32'h100, 32'h16, 1'b0, 0);
      op(1'b1, G + 32'h100, 32'h00, 1'b0, 0);
      `CHK(unlocked, 1'b0)
      M.unlock();
      @(posedge clk_sys);
      #1;
      `CHK(unlocked, 1'b1)
      op(1'b0, G + 32'h100, 0, 1'b0, 32'h1);
      op(1'b1, G + 32'h18, 32'hFFFF_FFFF, 1'b0, 0);
      op(1'b0, G + 32'h18, 0, 1'b0, 32'hFF);
      `CHK(supplyDroopCfg, 32'h0000_00FF)
      op(1'b1, G + 32'h24, 32'h1234_5678, 1'b0, 0);
      op(1'b0, G + 32'h24, 0, 1'b0, 32'h1234_5678);
      `CHK(powerupResetCfg, 32'h1234_5678)
      $display("test protection done");
      op(1'b1, G + 32'hC, 32'hFFFF_FFFF, 1'b0, 0);
      repeat (3) @(posedge clk_sys);
      op(1'b0, G + 32'hC, 0, 1'b0, 32'h1033_313E);
      `CHK(moduleReset, 32'h1033_313E)
      op(1'b1, G + 32'hC, 0, 1'b0, 0);
      #1;
      `CHK(moduleReset, 32'h0)
      $display("test module_reset done");
      chipHi = 0;
      cpuHi  = 0;
      op(1'b1, G + 32'h8, 32'h2, 1'b0, 0);
      repeat (5) @(posedge clk_sys);
      `CHK(cpuHi, 2)
      `CHK(chipHi, 0)
      op(1'b0, G + 32'h8, 0, 1'b0, 0);
      op(1'b0, G + 32'h4, 0, 1'b0, 32'h80);
      op(1'b1, G + 32'h8, 32'h8, 1'b0, 0);
      repeat (5) @(posedge clk_sys);
      op(1'b0, G + 32'h8, 0, 1'b0, 32'h8);
      op(1'b1, G + 32'h8, 32'h1, 1'b0, 0);
      repeat (5) @(posedge clk_sys);
      `CHK(chipHi, 2)
      op(1'b0, G + 32'h4, 0, 1'b0, 32'h81);
      op(1'b1, G + 32'h4, 0, 1'b0, 0);
      op(1'b0, G + 32'h4, 0, 1'b0, 32'h81);
      op(1'b1, G + 32'h4, 32'hFF, 1'b0, 0);
      op(1'b0, G + 32'h4, 0, 1'b0, 0);
      $display("test one_shot done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         #1;
         ev[i] = 1'b1;
         @(posedge clk_sys);
         #1;
         ev[i] = 1'b0;
         op(1'b0, G + 32'h4, 0, 1'b0, (32'h1 << (i + 1)) - 32'h1);
      end
      op(1'b1, G + 32'h4, 32'h15, 1'b0, 0);
      op(1'b0, G + 32'h4, 0, 1'b0, 32'h2A);
      op(1'b1, G + 32'h4, 32'hFFFF_FFFF, 1'b0, 0);
      op(1'b0, G + 32'h4, 0, 1'b0, 0);
      $display("test events done");
      op(1'b1, G + 32'h30, 32'h1122_3344, 1'b0, 0);
      op(1'b1, G + 32'h1FC, 32'hFFFF_FFFF, 1'b1, 0);
      op(1'b1, 32'h7000_0030, 0, 1'b1, 0);
      op(1'b0, G + 32'h30, 0, 1'b0, 32'h1122_3344);
      `CHK(portFuncSel[0], 32'h1122_3344)
      op(1'b1, G, 32'hFFFF_FFFF, 1'b0, 0);
      op(1'b0, G, 0, 1'b0, PART);
      op(1'b1, G + 32'h100, 0, 1'b0, 0);
      @(posedge clk_sys);
      #1;
      `CHK(unlocked, 1'b0)
      op(1'b1, G + 32'h8, 32'h1, 1'b0, 0);
      repeat (5) @(posedge clk_sys);
      op(1'b0, G + 32'h4, 0, 1'b0, 0);
      for (int i = 1; i < 4; i++) begin
         op(1'b1, G + 32'h30 + 32'(4 * i), 32'h0101_0101 * i, 1'b0, 0);
         op(1'b0, G + 32'h30 + 32'(4 * i), 0, 1'b0, 32'h0101_0101 * i);
         `CHK(portFuncSel[i], 32'h0101_0101 * i)
      end
      $display("test refusals done");
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      close_out();
   end
endmodule : system_address_decode_and_global_control_test
